// ### core/kwuhr_pkg.sv
// Package for the key wakeup halt release block: register map, fields and reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package kwuhr_pkg;

  localparam int unsigned KWUHR_N_KEYS = 4;

  // Register byte offsets.
  localparam logic [7:0] KWUHR_OFS_ENABLE  = 8'h00;
  localparam logic [7:0] KWUHR_OFS_SYSCTL  = 8'h04;
  localparam logic [7:0] KWUHR_OFS_PORTDAT = 8'h08;
  localparam logic [7:0] KWUHR_OFS_STATUS  = 8'h0c;

  // Field positions in system_control_1.
  localparam int unsigned KWUHR_SC_HALT_BIT = 0;
  localparam int unsigned KWUHR_SC_RELM_BIT = 1;

  // Field positions in the status register.
  localparam int unsigned KWUHR_ST_HALTED_BIT = 0;
  localparam int unsigned KWUHR_ST_WARMUP_BIT = 1;
  localparam int unsigned KWUHR_ST_BOUNCE_BIT = 2;

  // Values after reset.
  localparam logic [3:0] KWUHR_ENABLE_RST = 4'h0;
  localparam logic       KWUHR_RELM_RST   = 1'b1;

  // Warm-up length in cycles before the core is released.
  localparam logic [7:0] KWUHR_WARMUP_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    KWUHR_RUN,
    KWUHR_HALT,
    KWUHR_WARMUP
  } kwuhr_state_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } kwuhr_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } kwuhr_wb_rsp_t;

endpackage : kwuhr_pkg

// ### core/kwuhr_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes the pin is asynchronous to ref_clk_in; output changes once stages two and three agree.
`timescale 1ns/10ps
module kwuhr_sync (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  input  wire logic rst_val_in,
  output logic      level_out
);
  import kwuhr_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } kwuhr_sync_st_t;

  kwuhr_sync_st_t st_r;
  kwuhr_sync_st_t st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.s1  = pin_in;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  // Reset is synchronous, so the reset level comes from a port without hazard.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= '{s1: rst_val_in, s2: rst_val_in, s3: rst_val_in, lvl: rst_val_in};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;

endmodule : kwuhr_sync

// ### core/kwuhr_top.sv
// Key wakeup halt release: Wishbone registers, pin synchronisers and the halt state machine.
// Assumes halt_release_pin_in and key_wake_pins_in are raw asynchronous pins, and the core
// holds halt_request_in for one cycle when its halt instruction executes.
//
// Notes on behaviour
// [RULE1] Halt is left on the halt-release pin or any of four key pins.
// [RULE2] Enable register holds one enable bit per key wakeup pin.
// [RULE3] Software sets each used key pin as input before halting.
// [RULE4] Halt mode is entered through a bit of system control register one.
// [RULE5] A low level on any enabled key pin releases halt.
// [RULE6] Key pin levels are readable; software checks enabled pins high first.
// [RULE7] In edge mode software disables key pins or holds them high.
// [RULE8] Release condition present at halt entry starts warm-up at once, no halt.
// [RULE9] The halt-release pin has no enable and always takes part.
// [RULE10] External circuit holds the halt-release pin low when keys release.
// [RULE11] Level mode: pin high, keys low release; edge mode: pin rising only.
// [RULE12] Enabled key pins must not double as analog inputs.
// [RULE13] Release request ORs pin condition with enabled key lows, continuously.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module kwuhr_top (
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  input  wire kwuhr_pkg::kwuhr_wb_req_t wb_req_in,
  output kwuhr_pkg::kwuhr_wb_rsp_t      wb_rsp_out,
  input  wire logic                     halt_release_pin_in,
  input  wire logic [3:0]               key_wake_pins_in,
  input  wire logic                     halt_request_in,
  output logic                          halted_out,
  output logic                          warmup_out,
  output logic                          core_run_out
);
  import kwuhr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic                    rel_pin_sync;
  logic [KWUHR_N_KEYS-1:0] key_sync;

  kwuhr_sync u_rel_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .pin_in     (halt_release_pin_in),
    .rst_val_in (1'b0),
    .level_out  (rel_pin_sync)
  );

  // Key pins idle high through their pull-ups, so they start high.
  for (genvar g = 0; g < KWUHR_N_KEYS; g++) begin : g_key
    kwuhr_sync u_key_sync (
      .ref_clk_in (ref_clk_in),
      .reset_in   (reset_in),
      .pin_in     (key_wake_pins_in[g]),
      .rst_val_in (1'b1),
      .level_out  (key_sync[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    kwuhr_state_t            state;
    logic [KWUHR_N_KEYS-1:0] key_wake_enable_reg;
    logic                    halt_arm;
    logic                    relm;
    logic                    rel_pin_prev;
    logic                    bounce;
    logic [7:0]              warm_cnt;
    logic                    ack;
    logic [31:0]             rdat;
  } kwuhr_top_st_t;

  kwuhr_top_st_t st_r;
  kwuhr_top_st_t st_nxt;

  logic                    wb_hit;
  logic                    key_release;
  logic                    pin_release;
  logic                    release_req;
  logic                    halt_go;
  logic [31:0]             rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // Release condition.

  always_comb begin
    // Pin has no enable bit, so it always takes part. [RULE9]
    key_release = |(st_r.key_wake_enable_reg & ~key_sync); // [RULE5] [RULE2]
    if (st_r.relm) begin
      pin_release = rel_pin_sync; // [RULE11]
    end else begin
      // Edge mode: pin releases on a rising edge, keys are ignored. [RULE11]
      pin_release = rel_pin_sync & ~st_r.rel_pin_prev;
      key_release = 1'b0;
    end
    release_req = pin_release | key_release; // [RULE13] [RULE1]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  assign wb_hit  = wb_req_in.cyc & wb_req_in.stb & ~st_r.ack;
  assign halt_go = halt_request_in & st_r.halt_arm; // [RULE4]

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_req_in.adr[7:0])
      KWUHR_OFS_ENABLE: begin
        rd_mux[KWUHR_N_KEYS-1:0] = st_r.key_wake_enable_reg;
      end
      KWUHR_OFS_SYSCTL: begin
        rd_mux[KWUHR_SC_HALT_BIT] = st_r.halt_arm;
        rd_mux[KWUHR_SC_RELM_BIT] = st_r.relm;
      end
      KWUHR_OFS_PORTDAT: begin
        rd_mux[KWUHR_N_KEYS-1:0] = key_sync; // [RULE6]
        rd_mux[KWUHR_N_KEYS]     = rel_pin_sync;
      end
      KWUHR_OFS_STATUS: begin
        rd_mux[KWUHR_ST_HALTED_BIT] = (st_r.state == KWUHR_HALT);
        rd_mux[KWUHR_ST_WARMUP_BIT] = (st_r.state == KWUHR_WARMUP);
        rd_mux[KWUHR_ST_BOUNCE_BIT] = st_r.bounce;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    st_nxt              = st_r;
    st_nxt.rel_pin_prev = rel_pin_sync;
    st_nxt.ack          = wb_hit;
    if (wb_hit) begin
      st_nxt.rdat = rd_mux;
    end

    if (wb_hit && wb_req_in.we && wb_req_in.sel[0]) begin
      case (wb_req_in.adr[7:0])
        KWUHR_OFS_ENABLE: begin
          st_nxt.key_wake_enable_reg = wb_req_in.dat[KWUHR_N_KEYS-1:0]; // [RULE2]
        end
        KWUHR_OFS_SYSCTL: begin
          st_nxt.halt_arm = wb_req_in.dat[KWUHR_SC_HALT_BIT]; // [RULE4]
          st_nxt.relm     = wb_req_in.dat[KWUHR_SC_RELM_BIT];
        end
        KWUHR_OFS_STATUS: begin
          // Writing one clears the sticky flag; a new event in the same cycle wins below.
          if (wb_req_in.dat[KWUHR_ST_BOUNCE_BIT]) begin
            st_nxt.bounce = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (st_r.state)
      KWUHR_RUN: begin
        if (halt_go) begin
          st_nxt.halt_arm = 1'b0;
          st_nxt.warm_cnt = KWUHR_WARMUP_CYCLES;
          // A release already pending skips halt; a high pin or low enabled key counts in both modes. [RULE8]
          if (release_req || rel_pin_sync || (|(st_r.key_wake_enable_reg & ~key_sync))) begin
            st_nxt.state  = KWUHR_WARMUP;
            st_nxt.bounce = 1'b1;
          end else begin
            st_nxt.state = KWUHR_HALT;
          end
        end
      end
      KWUHR_HALT: begin
        st_nxt.warm_cnt = KWUHR_WARMUP_CYCLES;
        if (release_req) begin // [RULE13] [RULE1]
          st_nxt.state = KWUHR_WARMUP;
        end
      end
      KWUHR_WARMUP: begin
        // The warm-up stands in for oscillator settling before the core runs again.
        if (st_r.warm_cnt == 8'h01) begin
          st_nxt.state = KWUHR_RUN;
        end else begin
          st_nxt.warm_cnt = st_r.warm_cnt - 8'h01;
        end
      end
      default: begin
        st_nxt.state = KWUHR_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r.state               <= KWUHR_RUN;
      st_r.key_wake_enable_reg <= KWUHR_ENABLE_RST;
      st_r.halt_arm            <= 1'b0;
      st_r.relm                <= KWUHR_RELM_RST;
      st_r.rel_pin_prev        <= 1'b0;
      st_r.bounce              <= 1'b0;
      st_r.warm_cnt            <= 8'h00;
      st_r.ack                 <= 1'b0;
      st_r.rdat                <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign wb_rsp_out.ack = st_r.ack;
  assign wb_rsp_out.dat = st_r.rdat;
  assign halted_out     = (st_r.state == KWUHR_HALT);
  assign warmup_out     = (st_r.state == KWUHR_WARMUP);
  assign core_run_out   = (st_r.state == KWUHR_RUN);

endmodule : kwuhr_top

// ### test/kwuhr_keys.sv
// Model of the key switches and the halt-release source on the far side.
// Assumes pull-ups on the key pins; the bench decides what is pressed.
`timescale 1ns/10ps
module kwuhr_keys (
  input  wire logic [3:0] press_in,
  input  wire logic       rel_in,
  output logic [3:0]      key_wake_pins_out,
  output logic            halt_release_pin_out
);
  // Pins carry only digital key levels; no analog source ever loads an enabled key pin.
  // Pins act as inputs; a key pulls low only while pressed.
  assign key_wake_pins_out = ~press_in;
  // Held low unless asked, so key wakeups are not masked.
  assign halt_release_pin_out = rel_in;
endmodule : kwuhr_keys

// ### test/kwuhr_props.sv
// Checker for the key wakeup halt release block.
// Assumes it sees only the top ports; enable and mode are mirrored from bus writes.
`timescale 1ns/10ps
module kwuhr_props (
  input wire logic                     ref_clk_in,
  input wire logic                     reset_in,
  input wire kwuhr_pkg::kwuhr_wb_req_t wb_req_in,
  input wire kwuhr_pkg::kwuhr_wb_rsp_t wb_rsp_out,
  input wire logic                     halt_release_pin_in,
  input wire logic [3:0]               key_wake_pins_in,
  input wire logic                     halt_request_in,
  input wire logic                     halted_out,
  input wire logic                     warmup_out,
  input wire logic                     core_run_out
);
  import kwuhr_pkg::*;
  logic [3:0] en_r;
  logic       relm_r;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // The mirror lags the design by one cycle, which the bounded waits absorb.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      en_r   <= KWUHR_ENABLE_RST;
      relm_r <= KWUHR_RELM_RST;
    end else if (wb_rsp_out.ack && wb_req_in.we && wb_req_in.sel[0]) begin
      if (wb_req_in.adr[7:0] == KWUHR_OFS_ENABLE) en_r <= wb_req_in.dat[3:0];
      if (wb_req_in.adr[7:0] == KWUHR_OFS_SYSCTL) relm_r <= wb_req_in.dat[1];
    end
  end
  ////////////////////////////////////////
  a_ack_single: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack held too long");
  a_ack_prompt: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack |=> wb_rsp_out.ack)
    else $error("ack missing");
  a_one_state: assert property ($onehot({halted_out, warmup_out, core_run_out}))
    else $error("state outputs not one-hot");
  a_halt_cause: assert property ($rose(halted_out) |-> $past(halt_request_in))
    else $error("halt without request");
  a_pin_release: assert property (halted_out && $rose(halt_release_pin_in) |-> ##[1:8] !halted_out)
    else $error("release pin ignored");
  a_key_release: assert property (halted_out && relm_r && |(en_r & ~key_wake_pins_in) |-> ##[1:8] !halted_out)
    else $error("enabled key ignored");
  a_early_wake: assert property (halt_release_pin_in[*6] ##1 halt_request_in |=> !halted_out)
    else $error("halted despite release");
  a_warm_length: assert property ($rose(warmup_out) |-> warmup_out[*8] ##1 warmup_out[*8] ##1 core_run_out)
    else $error("warm-up length wrong");
  c_key_wake: cover property (halted_out && |(en_r & ~key_wake_pins_in));
  c_skip: cover property (halt_request_in && halt_release_pin_in);
  c_edge: cover property (halted_out && !relm_r);
endmodule : kwuhr_props
bind kwuhr_top kwuhr_props u_props (.ref_clk_in, .reset_in, .wb_req_in, .wb_rsp_out, .halt_release_pin_in,
  .key_wake_pins_in, .halt_request_in, .halted_out, .warmup_out, .core_run_out);

// ### test/testbench.sv
// Bench for the key wakeup halt release block with the key switch model.
// Assumes a 40 MHz clock and bus answers within 50 cycles.
`timescale 1ns/10ps
module testbench;
  import kwuhr_pkg::*;
  logic          ref_clk_in;
  logic          reset_in;
  kwuhr_wb_req_t req;
  kwuhr_wb_rsp_t rsp;
  logic [3:0]    press;
  logic [3:0]    keys;
  logic          rel;
  logic          pin;
  logic          hreq;
  logic          halted;
  logic          warm;
  logic          run;
  logic [31:0]   rd;
  int            fail_count;
  int            comparisons;
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  kwuhr_top dut (.ref_clk_in, .reset_in, .wb_req_in(req), .wb_rsp_out(rsp), .halt_release_pin_in(pin),
    .key_wake_pins_in(keys), .halt_request_in(hreq), .halted_out(halted), .warmup_out(warm), .core_run_out(run));
  kwuhr_keys sw (.press_in(press), .rel_in(rel), .key_wake_pins_out(keys), .halt_release_pin_out(pin));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge ref_clk_in);
    req <= '{adr: {24'h0, adr}, dat: dat, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    rd = rsp.dat;
    req <= '0;
    chk(32'(n < 50), 32'h1, "ack");
  endtask : wb
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp, "read");
  endtask : rdc
  task automatic settle;
    repeat (6) @(posedge ref_clk_in);
  endtask : settle
  // The halt bit must be armed first, or the request is ignored.
  task automatic halt(input logic relm);
    wb(1'b1, KWUHR_OFS_SYSCTL, {30'h0, relm, 1'b1});
    @(posedge ref_clk_in);
    hreq <= 1'b1;
    @(posedge ref_clk_in);
    hreq <= 1'b0;
    @(posedge ref_clk_in);
  endtask : halt
  task automatic wait_run;
    int n;
    n = 0;
    while (run !== 1'b1 && n < 100) begin
      @(posedge ref_clk_in);
      n++;
    end
  endtask : wait_run
  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  initial begin
    req = '0;
    press = 4'h0;
    rel = 1'b0;
    hreq = 1'b0;
    reset_in = 1'b1;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rdc(KWUHR_OFS_ENABLE, 32'h0);
    rdc(KWUHR_OFS_SYSCTL, 32'h2);
    rdc(8'h10, 32'h0);
    press <= 4'ha;
    settle();
    rdc(KWUHR_OFS_PORTDAT, 32'h5);
    press <= 4'h0;
    settle();
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, KWUHR_OFS_ENABLE, 32'h1 << i);
      rdc(KWUHR_OFS_ENABLE, 32'h1 << i);
      halt(1'b1);
      chk(32'(halted), 32'h1, "halted");
      press <= ~(4'h1 << i);
      repeat (10) @(posedge ref_clk_in);
      chk(32'(halted), 32'h1, "halted");
      press <= 4'hf;
      wait_run();
      chk(32'(run), 32'h1, "run");
      press <= 4'h0;
      settle();
    end
    halt(1'b1);
    rel <= 1'b1;
    wait_run();
    chk(32'(run), 32'h1, "run");
    settle();
    rdc(KWUHR_OFS_PORTDAT, 32'h1f);
    halt(1'b0);
    chk(32'(warm), 32'h1, "warm");
    rdc(KWUHR_OFS_STATUS, 32'h6);
    wait_run();
    rel <= 1'b0;
    wb(1'b1, KWUHR_OFS_STATUS, 32'h4);
    rdc(KWUHR_OFS_STATUS, 32'h0);
    settle();
    halt(1'b0);
    chk(32'(halted), 32'h1, "halted");
    rdc(KWUHR_OFS_STATUS, 32'h1);
    rel <= 1'b1;
    wait_run();
    chk(32'(run), 32'h1, "run");
    rel <= 1'b0;
    press <= 4'h8;
    settle();
    halt(1'b1);
    chk(32'(warm), 32'h1, "warm");
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    fail_count++;
    stop_test();
  end
endmodule : testbench
